// *** src/risc14_pkg.sv ***
// Shared constants, types and decode functions for the 14-bit instruction decoder.
package risc14_pkg;
  // ==========================================================================
  // Widths and timing
  localparam int WORD_W = 14;
  localparam int PC_W = 15;
  localparam int F_W = 7;
  localparam logic [3:0] PHASE_RST = 4'h1;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic [PC_W-1:0] PC_ONE = 15'h0001;
  localparam logic [WORD_W-1:0] INSTR_RST = 14'h0000;
  localparam logic [5:0] IND_PAGE = 6'h00;
  // ==========================================================================
  // Operation codes, byte and literal formats (bits 13..8)
  localparam logic [5:0] OP_MOVWF = 6'h00;
  localparam logic [5:0] OP_CLRF = 6'h01;
  localparam logic [5:0] OP_SUBWF = 6'h02;
  localparam logic [5:0] OP_DECF = 6'h03;
  localparam logic [5:0] OP_IORWF = 6'h04;
  localparam logic [5:0] OP_ANDWF = 6'h05;
  localparam logic [5:0] OP_XORWF = 6'h06;
  localparam logic [5:0] OP_ADDWF = 6'h07;
  localparam logic [5:0] OP_MOVF = 6'h08;
  localparam logic [5:0] OP_COMF = 6'h09;
  localparam logic [5:0] OP_INCF = 6'h0a;
  localparam logic [5:0] OP_DECSZ = 6'h0b;
  localparam logic [5:0] OP_SWAPF = 6'h0e;
  localparam logic [5:0] OP_INCSZ = 6'h0f;
  localparam logic [5:0] OP_MOVLW = 6'h30;
  localparam logic [5:0] OP_RETLIT = 6'h34;
  localparam logic [5:0] OP_IORLW = 6'h38;
  localparam logic [5:0] OP_ANDLW = 6'h39;
  localparam logic [5:0] OP_XORLW = 6'h3a;
  localparam logic [5:0] OP_SUBLW = 6'h3c;
  localparam logic [5:0] OP_ADDLW = 6'h3e;
  // Other formats.
  localparam logic [1:0] GRP_BIT = 2'h1;
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [2:0] OP_CALL = 3'h4;
  localparam logic [2:0] OP_JUMP = 3'h5;
  localparam logic [4:0] OP_BRANCH = 5'h19;
  localparam logic [6:0] OP_PTRADD = 7'h62;
  localparam logic [6:0] SUB_RET = 7'h08;
  localparam logic [6:0] SUB_INTRET = 7'h09;
  localparam logic [6:0] SUB_CALLACC = 7'h0a;
  localparam logic [6:0] SUB_BRACC = 7'h0b;
  // ==========================================================================
  // Types
  typedef enum logic [2:0] {S_EXEC = 3'b001, S_FLUSH = 3'b010, S_STALL = 3'b100} state_t;
  typedef enum logic [3:0] {C_NOP, C_BYTE, C_SKIPF, C_BITW, C_BITSKIP, C_LIT, C_RETURN_WITH_LITERAL,
    C_ABSOLUTE_JUMP, C_CALL, C_BRA, C_BRW, C_CALL_VIA_ACCUMULATOR, C_RET, C_INTERRUPT_RETURN, C_PTRADD} class_t;
  typedef enum logic [3:0] {A_ADD, A_SUB, A_AND, A_OR, A_XOR, A_CLR, A_COM, A_DEC,
    A_INC, A_MOV, A_MOVW, A_SWAP, A_BCLR, A_BSET} alu_op_t;
  // ==========================================================================
  // Decode functions
  function automatic class_t word_class(input logic [WORD_W-1:0] w);
    class_t c;
    c = C_NOP;
    if (w[13:11] == OP_CALL) c = C_CALL;
    else if (w[13:11] == OP_JUMP) c = C_ABSOLUTE_JUMP;
    else if (w[13:9] == OP_BRANCH) c = C_BRA;
    else if (w[13:8] == OP_RETLIT) c = C_RETURN_WITH_LITERAL;
    else if (w[13:7] == OP_PTRADD) c = C_PTRADD;
    else if (w[13:8] inside {OP_MOVLW, OP_IORLW, OP_ANDLW, OP_XORLW, OP_SUBLW, OP_ADDLW})
      c = C_LIT;
    else if (w[13:12] == GRP_BIT) c = w[11] ? C_BITSKIP : C_BITW;
    else if (w[13:12] == GRP_BYTE) begin
      if (w[13:8] inside {OP_DECSZ, OP_INCSZ}) c = C_SKIPF;
      else if (w[13:8] != OP_MOVWF || w[7]) c = C_BYTE;
      else if (w[6:0] == SUB_RET) c = C_RET;
      else if (w[6:0] == SUB_INTRET) c = C_INTERRUPT_RETURN;
      else if (w[6:0] == SUB_CALLACC) c = C_CALL_VIA_ACCUMULATOR;
      else if (w[6:0] == SUB_BRACC) c = C_BRW;
    end
    return c;
  endfunction

  function automatic alu_op_t word_op(input logic [WORD_W-1:0] w);
    alu_op_t o;
    o = A_MOV;
    if (w[13:12] == GRP_BIT) o = w[10] ? A_BSET : A_BCLR;
    else begin
      case (w[13:8])
        OP_MOVWF: o = A_MOVW;
        OP_CLRF: o = A_CLR;
        OP_SUBWF, OP_SUBLW: o = A_SUB;
        OP_DECF, OP_DECSZ: o = A_DEC;
        OP_IORWF, OP_IORLW: o = A_OR;
        OP_ANDWF, OP_ANDLW: o = A_AND;
        OP_XORWF, OP_XORLW: o = A_XOR;
        OP_ADDWF, OP_ADDLW: o = A_ADD;
        OP_COMF: o = A_COM;
        OP_INCF, OP_INCSZ: o = A_INC;
        OP_SWAPF: o = A_SWAP;
        default: o = A_MOV;
      endcase
    end
    return o;
  endfunction
endpackage

// *** src/phase_gen.sv ***
// Four-phase sequencer that splits each instruction cycle into oscillator clocks.
`timescale 1ns/1ps
`default_nettype none
module phase_gen (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // One-hot phase, bit 0 is the first clock of a cycle
  output logic [3:0] phase
);
  import risc14_pkg::*;

  // ==========================================================================
  // Phase ring
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= PHASE_RST;
    end else begin
      phase <= {phase[2:0], phase[3]};
    end
  end
endmodule
`default_nettype wire

// *** src/risc14_alu.sv ***
// Byte arithmetic and logic unit used for the modify step.
`timescale 1ns/1ps
`default_nettype none
module risc14_alu (
  // Operands
  input wire risc14_pkg::alu_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] w,
  input wire logic [2:0] bit_idx,
  // Result
  output logic [7:0] result,
  output logic zero
);
  import risc14_pkg::*;

  // ==========================================================================
  // Operation select
  always_comb begin
    unique case (op)
      A_ADD: result = a + w;
      A_SUB: result = a - w;
      A_AND: result = a & w;
      A_OR: result = a | w;
      A_XOR: result = a ^ w;
      A_CLR: result = 8'h00;
      A_COM: result = ~a;
      A_DEC: result = a - 8'h01;
      A_INC: result = a + 8'h01;
      A_MOV: result = a;
      A_MOVW: result = w;
      A_SWAP: result = {a[3:0], a[7:4]};
      A_BCLR: result = a & ~(8'h01 << bit_idx);
      A_BSET: result = a | (8'h01 << bit_idx);
      default: result = a;
    endcase
    zero = (result == 8'h00);
  end
endmodule
`default_nettype wire

// *** src/risc14_instruction_decode.sv ***
// Instruction fetch, decode and read-modify-write sequencing for a 14-bit word core.
`timescale 1ns/1ps
`default_nettype none
module risc14_instruction_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Program memory, combinational read of prog_addr
  output logic [risc14_pkg::PC_W-1:0] prog_addr,
  input wire logic [risc14_pkg::WORD_W-1:0] prog_word,
  // File registers
  output logic [risc14_pkg::F_W-1:0] file_addr,
  output logic file_rd_en,
  input wire logic [7:0] file_rd_data,
  output logic file_wr_en,
  output logic [7:0] file_wr_data,
  input wire logic [1:0] ptr_in_prog,
  // Pointer adjust
  output logic ptr_add_en,
  output logic ptr_num,
  output logic [5:0] ptr_offset,
  // Return stack
  output logic stack_push,
  output logic stack_pop,
  output logic [risc14_pkg::PC_W-1:0] push_addr,
  input wire logic [risc14_pkg::PC_W-1:0] stack_top,
  output logic int_return,
  // Working register
  output logic [7:0] acc
);
  import risc14_pkg::*;

  // ==========================================================================
  // Decode
  logic [3:0] phase;
  state_t st;
  logic [WORD_W-1:0] instr;
  class_t cls;
  alu_op_t op;
  logic [7:0] operand;
  logic [7:0] alu_a;
  logic [7:0] result;
  logic res_zero;
  logic extra_done;
  logic skip_hit;
  logic uses_file;
  logic needs_extra;
  logic start_stall;
  logic bit_val;
  logic skip_cond;
  logic taken;
  logic dest_file;
  logic [PC_W-1:0] next_pc;

  phase_gen u_phase (
    .clk(clk),
    .arst_n(arst_n),
    .phase(phase)
  );

  assign cls = word_class(instr);
  assign op = word_op(instr);
  assign uses_file = cls inside {C_BYTE, C_SKIPF, C_BITW, C_BITSKIP};
  // The low address bit names which pointer the indirect register uses.
  assign needs_extra = uses_file && (instr[6:1] == IND_PAGE) && ptr_in_prog[instr[0]];
  assign start_stall = phase[0] && (st == S_EXEC) && needs_extra && !extra_done;
  assign alu_a = uses_file ? operand : instr[7:0];
  assign bit_val = operand[instr[9:7]];
  assign skip_cond = (cls == C_SKIPF) ? res_zero : (instr[10] ? bit_val : !bit_val);
  assign dest_file = (cls == C_BITW) || ((cls inside {C_BYTE, C_SKIPF}) && instr[7]);
  assign taken = skip_hit || (cls inside {C_ABSOLUTE_JUMP, C_CALL, C_BRA, C_BRW, C_CALL_VIA_ACCUMULATOR,
    C_RET, C_RETURN_WITH_LITERAL, C_INTERRUPT_RETURN});

  risc14_alu u_alu (
    .op(op),
    .a(alu_a),
    .w(acc),
    .bit_idx(instr[9:7]),
    .result(result),
    .zero(res_zero)
  );

  // ==========================================================================
  // Next program address
  always_comb begin
    unique case (cls)
      C_ABSOLUTE_JUMP, C_CALL: next_pc = {prog_addr[PC_W-1:11], instr[10:0]};
      C_BRA: next_pc = prog_addr + {{(PC_W-9){instr[8]}}, instr[8:0]};
      C_BRW: next_pc = prog_addr + {{(PC_W-8){1'b0}}, acc};
      C_CALL_VIA_ACCUMULATOR: next_pc = {prog_addr[PC_W-1:8], acc};
      C_RET, C_RETURN_WITH_LITERAL, C_INTERRUPT_RETURN: next_pc = stack_top;
      default: next_pc = prog_addr + PC_ONE;
    endcase
  end

  // ==========================================================================
  // Cycle sequencer
  // A taken flow change still loads the prefetched word; the flush cycle throws it away.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= S_FLUSH;
      prog_addr <= PC_RST;
      instr <= INSTR_RST;
      extra_done <= 1'b0;
    end else if (start_stall) begin
      st <= S_STALL;
    end else if (phase[3]) begin
      unique case (st)
        S_FLUSH: begin
          instr <= prog_word;
          prog_addr <= prog_addr + PC_ONE;
          st <= S_EXEC;
        end
        S_STALL: begin
          extra_done <= 1'b1;
          st <= S_EXEC;
        end
        S_EXEC: begin
          extra_done <= 1'b0;
          instr <= prog_word;
          prog_addr <= next_pc;
          st <= taken ? S_FLUSH : S_EXEC;
        end
        default: st <= S_FLUSH;
      endcase
    end
  end

  // ==========================================================================
  // Skip decision
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      skip_hit <= 1'b0;
    end else if (phase[2]) begin
      skip_hit <= (cls inside {C_SKIPF, C_BITSKIP}) && skip_cond;
    end
  end

  // ==========================================================================
  // File register read-modify-write
  // Write-only instructions still read first, so reads with side effects always happen.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      file_addr <= 7'h00;
      file_rd_en <= 1'b0;
      file_wr_en <= 1'b0;
      file_wr_data <= 8'h00;
      operand <= 8'h00;
    end else begin
      if (phase[0] && st == S_EXEC && !start_stall && uses_file) begin
        file_addr <= instr[6:0];
        file_rd_en <= 1'b1;
      end
      if (phase[1]) begin
        file_rd_en <= 1'b0;
        operand <= file_rd_data;
      end
      if (phase[2] && st == S_EXEC && dest_file) begin
        file_wr_en <= 1'b1;
        file_wr_data <= result;
      end
      if (phase[3]) begin
        file_wr_en <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Working register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc <= 8'h00;
    end else if (phase[2] && st == S_EXEC) begin
      if ((cls inside {C_BYTE, C_SKIPF}) && !instr[7]) begin
        acc <= result;
      end else if (cls inside {C_LIT, C_RETURN_WITH_LITERAL}) begin
        acc <= result;
      end
    end
  end

  // ==========================================================================
  // Stack and pointer strobes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      push_addr <= PC_RST;
      int_return <= 1'b0;
      ptr_add_en <= 1'b0;
      ptr_num <= 1'b0;
      ptr_offset <= 6'h00;
    end else begin
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      int_return <= 1'b0;
      ptr_add_en <= 1'b0;
      if (phase[3] && st == S_EXEC) begin
        if (cls inside {C_CALL, C_CALL_VIA_ACCUMULATOR}) begin
          stack_push <= 1'b1;
          push_addr <= prog_addr;
        end
        if (cls inside {C_RET, C_RETURN_WITH_LITERAL, C_INTERRUPT_RETURN}) begin
          stack_pop <= 1'b1;
        end
        int_return <= (cls == C_INTERRUPT_RETURN);
      end
      if (phase[2] && st == S_EXEC && cls == C_PTRADD) begin
        ptr_add_en <= 1'b1;
        ptr_num <= instr[6];
        ptr_offset <= instr[5:0];
      end
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  phase_onehot_a: assert property ($onehot(phase))
    else $error("phase is not one-hot");
  // The ring rests on its first phase one extra clock as reset lets go, so key off its rise.
  cycle_length_a: assert property ($rose(phase[0]) |=> (!phase[0]) [*3] ##1 phase[0])
    else $error("instruction cycle is not four clocks");
  read_first_a: assert property ($rose(file_wr_en) |-> $past(file_rd_en, 2))
    else $error("file write without prior read");
  write_addr_a: assert property (file_wr_en |-> file_addr == instr[6:0])
    else $error("write address differs from instruction field");
  dest_select_a: assert property (file_wr_en && (cls inside {C_BYTE, C_SKIPF}) |-> instr[7])
    else $error("file written with d equal 0");
  acc_dest_a: assert property ($changed(acc) && (cls inside {C_BYTE, C_SKIPF})
    |-> !instr[7] && !file_wr_en)
    else $error("accumulator written with d equal 1");
  bit_write_a: assert property (file_wr_en && cls == C_BITW
    |-> file_wr_data[instr[9:7]] == instr[10])
    else $error("bit operation wrote wrong bit value");
  call_two_a: assert property (stack_push |-> st == S_FLUSH ##4 st == S_EXEC)
    else $error("call did not take two cycles");
  return_two_a: assert property (stack_pop |-> st == S_FLUSH ##4 st == S_EXEC)
    else $error("return did not take two cycles");
  flush_len_a: assert property ($rose(st == S_FLUSH) |-> ##4 st == S_EXEC)
    else $error("flush cycle not one instruction cycle");
  stall_len_a: assert property ($rose(st == S_STALL) |-> ##3 st == S_EXEC && extra_done)
    else $error("indirect stall not one instruction cycle");
  skip_met_a: assert property (phase[3] && st == S_EXEC && skip_hit |=> st == S_FLUSH)
    else $error("met skip did not discard next word");
  skip_unmet_a: assert property (phase[3] && st == S_EXEC && !skip_hit
    && (cls inside {C_SKIPF, C_BITSKIP}) |=> st == S_EXEC)
    else $error("unmet skip took extra cycle");
  fetch_word_a: assert property (phase[3] && st != S_STALL && !start_stall
    |=> instr == $past(prog_word))
    else $error("instruction word not loaded");
  ring_turn_a: assert property (phase[3] |=> phase[0])
    else $error("phase ring did not wrap");
  read_addr_a: assert property (file_rd_en |-> file_addr == instr[6:0])
    else $error("read address differs from instruction field");
  rd_pulse_a: assert property (file_rd_en |=> !file_rd_en)
    else $error("read strobe longer than one clock");
  wr_pulse_a: assert property (file_wr_en |=> !file_wr_en)
    else $error("write strobe longer than one clock");
  flush_quiet_a: assert property (st == S_FLUSH |-> !file_rd_en && !file_wr_en)
    else $error("file access during flush cycle");
  stall_hold_a: assert property (st == S_STALL |=> $stable(prog_addr))
    else $error("fetch advanced during indirect stall");
  branch_flush_a: assert property (phase[3] && st == S_EXEC
    && (cls inside {C_ABSOLUTE_JUMP, C_BRA, C_BRW}) |=> st == S_FLUSH)
    else $error("branch did not add a flush cycle");
  single_cycle_a: assert property (phase[3] && st == S_EXEC
    && (cls inside {C_NOP, C_BYTE, C_BITW, C_LIT, C_PTRADD}) |=> st == S_EXEC)
    else $error("plain instruction took extra cycle");
  ptr_fields_a: assert property (ptr_add_en
    |-> ptr_num == instr[6] && ptr_offset == instr[5:0])
    else $error("pointer add fields differ from instruction");
  acc_literal_a: assert property (phase[3] && st == S_EXEC && cls == C_LIT
    && op == A_MOV |-> acc == instr[7:0])
    else $error("literal not loaded into accumulator");
  iret_pop_a: assert property (int_return |-> stack_pop)
    else $error("interrupt return strobe without pop");

  call_seen_c: cover property (stack_push ##5 stack_pop);
  skip_seen_c: cover property (phase[3] && st == S_EXEC && skip_hit);
  stall_seen_c: cover property ($rose(st == S_STALL));
  rmw_seen_c: cover property (file_rd_en ##2 file_wr_en);
  iret_seen_c: cover property (int_return);
endmodule
`default_nettype wire

// *** test/risc14_partner.sv ***
// Behavioural program memory, file registers and return stack facing the decoder.
`timescale 1ns/1ps
`default_nettype none
module risc14_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Program memory
  input wire logic [risc14_pkg::PC_W-1:0] prog_addr,
  output logic [risc14_pkg::WORD_W-1:0] prog_word,
  // File registers
  input wire logic [risc14_pkg::F_W-1:0] file_addr,
  input wire logic file_rd_en,
  output logic [7:0] file_rd_data,
  input wire logic file_wr_en,
  input wire logic [7:0] file_wr_data,
  // Return stack
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic [risc14_pkg::PC_W-1:0] push_addr,
  output logic [risc14_pkg::PC_W-1:0] stack_top
);
  import risc14_pkg::*;
  // ==========================================================================
  // Storage
  logic [WORD_W-1:0] rom [0:31];
  logic [7:0] regs [0:127];
  logic [PC_W-1:0] stk [0:15];
  logic [3:0] sp;
  // Out-of-range fetches read as a jump to address 0 so a runaway stays bounded.
  assign prog_word = (prog_addr < 15'h0020) ? rom[prog_addr[4:0]] : 14'h2800;
  // Outside the read strobe the data is inverted so a late sample cannot match by luck.
  assign file_rd_data = file_rd_en ? regs[file_addr] : ~regs[file_addr];
  assign stack_top = stk[sp - 4'h1];
  // ==========================================================================
  // Updates
  always @(posedge clk) begin
    if (file_wr_en) begin
      regs[file_addr] <= file_wr_data;
    end
  end
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sp <= 4'h0;
    end else if (stack_push) begin
      stk[sp] <= push_addr;
      sp <= sp + 4'h1;
    end else if (stack_pop) begin
      sp <= sp - 4'h1;
    end
  end
endmodule
`default_nettype wire

// *** test/tb_risc14_instruction_decode.sv ***
// Self-checking testbench for the instruction decoder.
`timescale 1ns/1ps
`default_nettype none
module tb_risc14_instruction_decode;
  import risc14_pkg::*;
  // ==========================================================================
  // Signals
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [1:0] ptr_in_prog = 2'h0;
  logic [PC_W-1:0] prog_addr, push_addr, stack_top;
  logic [WORD_W-1:0] prog_word;
  logic [F_W-1:0] file_addr;
  logic file_rd_en, file_wr_en, ptr_add_en, ptr_num, stack_push, stack_pop, int_return;
  logic [7:0] file_rd_data, file_wr_data, acc;
  logic [5:0] ptr_offset, got_off;
  logic rd_d1 = 1'b0;
  logic rd_d2 = 1'b0;
  logic got_num;
  logic [PC_W-1:0] got_push;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_ptr = 0;
  int n_iret = 0;
  int wt[$];
  logic [6:0] wa[$];
  logic [13:0] p[$];
  always #4 clk = ~clk;
  risc14_instruction_decode risc14_instruction_decode_inst (.clk(clk), .arst_n(arst_n),
    .prog_addr(prog_addr), .prog_word(prog_word), .file_addr(file_addr),
    .file_rd_en(file_rd_en), .file_rd_data(file_rd_data), .file_wr_en(file_wr_en),
    .file_wr_data(file_wr_data), .ptr_in_prog(ptr_in_prog), .ptr_add_en(ptr_add_en),
    .ptr_num(ptr_num), .ptr_offset(ptr_offset), .stack_push(stack_push),
    .stack_pop(stack_pop), .push_addr(push_addr), .stack_top(stack_top),
    .int_return(int_return), .acc(acc));
  risc14_partner risc14_partner_inst (.clk(clk), .arst_n(arst_n), .prog_addr(prog_addr),
    .prog_word(prog_word), .file_addr(file_addr), .file_rd_en(file_rd_en),
    .file_rd_data(file_rd_data), .file_wr_en(file_wr_en), .file_wr_data(file_wr_data),
    .stack_push(stack_push), .stack_pop(stack_pop), .push_addr(push_addr),
    .stack_top(stack_top));
  // ==========================================================================
  // Common tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Loads the program, resets the core and lets it run a fixed number of clocks.
  task automatic run(input int n, input logic [1:0] pip);
    @(posedge clk);
    arst_n <= 1'b0;
    ptr_in_prog <= pip;
    for (int i = 0; i < 32; i++) begin
      risc14_partner_inst.rom[i] = (i < p.size()) ? p[i] : (14'h2800 | 14'(i));
    end
    for (int i = 0; i < 128; i++) begin
      risc14_partner_inst.regs[i] = 8'h00;
    end
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    wt.delete();
    wa.delete();
    n_ptr = 0;
    n_iret = 0;
    repeat (n) @(posedge clk);
  endtask
  // Compares the order of file writes and the clocks between neighbours.
  task automatic check_writes(input logic [6:0] ea[$], input int ed[$]);
    check(wa.size(), ea.size(), "write count");
    for (int i = 0; i < ea.size() && i < wa.size(); i++) begin
      check(wa[i], ea[i], "write address");
      if (i > 0) begin
        check(wt[i] - wt[i-1], ed[i-1], "clocks between writes");
      end
    end
  endtask
  // ==========================================================================
  // Monitor
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_d1 <= file_rd_en;
    rd_d2 <= rd_d1;
    if (file_wr_en === 1'b1) begin
      wt.push_back(cyc);
      wa.push_back(file_addr);
      check(rd_d2, 1'b1, "write without a read two clocks earlier");
    end
    if (int_return === 1'b1) begin
      n_iret++;
    end
    if (stack_push === 1'b1) begin
      got_push = push_addr;
    end
    if (ptr_add_en === 1'b1) begin
      n_ptr++;
      got_num = ptr_num;
      got_off = ptr_offset;
    end
  end
  // ==========================================================================
  // Scenarios
  task automatic s_byte();
    p = '{14'h305a, 14'h00ff, 14'h077f, 14'h0aff, 14'h17ff, 14'h00b0, 14'h0103, 14'h00b1};
    run(80, 2'h0);
    check_writes('{7'h7f, 7'h7f, 7'h7f, 7'h30, 7'h31}, '{8, 4, 4, 8});
    check(risc14_partner_inst.regs[127], 8'hdb, "increment and bit set");
    check(risc14_partner_inst.regs[48], 8'hb4, "sum into accumulator");
    check(risc14_partner_inst.regs[49], 8'h00, "clear with don't-care bits");
  endtask
  task automatic s_flow();
    p = '{14'h3001, 14'h0090, 14'h2804, 14'h00fe, 14'h0091, 14'h2012, 14'h0092, 14'h2014,
      14'h0094, 14'h1c15, 14'h0096, 14'h1c16, 14'h00fe, 14'h0097, 14'h3201, 14'h00fe,
      14'h0098, 14'h2811, 14'h0093, 14'h0008, 14'h3477};
    run(200, 2'h0);
    check_writes('{7'h10, 7'h11, 7'h13, 7'h12, 7'h14, 7'h16, 7'h17, 7'h18},
      '{12, 12, 12, 20, 8, 12, 12});
    check(acc, 8'h77, "literal from return");
    check(risc14_partner_inst.regs[126], 8'h00, "skipped word written");
    check(n_iret, 0, "interrupt strobe on plain returns");
  endtask
  task automatic s_indirect();
    p = '{14'h3003, 14'h00a0, 14'h0080, 14'h00a1, 14'h0081, 14'h00a2, 14'h316a};
    run(80, 2'h1);
    check_writes('{7'h20, 7'h00, 7'h21, 7'h01, 7'h22}, '{8, 4, 4, 4});
    check(n_ptr, 1, "pointer add count");
    check(got_num, 1'b1, "pointer number");
    check(got_off, 6'h2a, "pointer offset");
  endtask
  // Decrement-skip both ways, branch by accumulator, call by accumulator, interrupt return.
  task automatic s_more();
    p = '{14'h3002, 14'h00c0, 14'h0bc0, 14'h0bc0, 14'h00fe, 14'h000b, 14'h00fe, 14'h00fe,
      14'h3010, 14'h000a, 14'h00c1, 14'h280b, 14'h00fe, 14'h00fe, 14'h00fe, 14'h00fe,
      14'h0009};
    run(80, 2'h0);
    check_writes('{7'h40, 7'h40, 7'h40, 7'h41}, '{4, 4, 36});
    check(risc14_partner_inst.regs[64], 8'h00, "decrement to zero");
    check(risc14_partner_inst.regs[65], 8'h10, "accumulator after call and return");
    check(risc14_partner_inst.regs[126], 8'h00, "skipped or jumped word written");
    check(got_push, 15'h000a, "return address of call via accumulator");
    check(n_iret, 1, "interrupt return strobe");
  endtask
  // ==========================================================================
  // Sequence and watchdog
  initial begin
    s_byte();
    s_flow();
    s_indirect();
    s_more();
    close_out();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    close_out();
  end
endmodule
`default_nettype wire
